// ==== dv/hfc_checker.sv ====
// Checker for hfc_top: bus timing, status codes, control outputs, irq.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module hfc_checker
  import hfc_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_nrst, // Reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_wb_cyc, // Bus cycle
  input wire logic i_wb_stb, // Strobe
  input wire logic i_wb_we, // Write enable
  input wire logic [9:2] i_wb_adr, // Register index
  input wire logic [3:0] i_wb_sel, // Byte lanes
  input wire logic [31:0] i_wb_dat, // Write data
  input wire logic [31:0] o_wb_dat, // Read data
  input wire logic o_wb_ack, // Acknowledge
  input wire logic [7:0] i_rx_count, // RX FIFO fill
  input wire logic [7:0] i_rx_threshold, // RX threshold
  input wire logic o_rx_fifo_flush, // RX FIFO reset
  input wire logic o_rx_enable, // Receiver on
  input wire logic o_rx_addr7, // Seven-bit address
  input wire logic o_tx_valid, // TX head valid
  input wire logic o_tx_cycle, // Cycle byte count
  input wire logic o_tx_crc_inhibit, // No CRC
  input wire logic o_irq // Interrupt request
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  logic tk, sr, cw, mw;
  logic [7:0] n, t;
  assign n = i_rx_count;
  assign t = i_rx_threshold;
  assign tk = i_wb_cyc & i_wb_stb & ~o_wb_ack & i_ce;
  assign sr = tk & ~i_wb_we & (i_wb_adr == HFC_IDX_STATUS);
  assign cw = tk & i_wb_we & i_wb_sel[0] & (i_wb_adr == HFC_IDX_CTRL2);
  assign mw = tk & i_wb_we & i_wb_sel[0] & (i_wb_adr == HFC_IDX_MASK);
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_reply_a: assert property (tk && i_wb_adr != HFC_IDX_TXDATA |=> o_wb_ack)
    else $error("request not acked");
  st_empty_a: assert property (sr && (o_rx_fifo_flush || n == 8'h00)
    |=> o_wb_dat[1:0] == HFC_RX_EMPTY) else $error("status not empty");
  st_below_a: assert property (sr && !o_rx_fifo_flush && n != 0 && n < t
    |=> o_wb_dat[1:0] == HFC_RX_BELOW) else $error("status not below");
  st_above_a: assert property (sr && !o_rx_fifo_flush && n != 0 && n >= t
    |=> o_wb_dat[1:0] == HFC_RX_ABOVE) else $error("status not above");
  ctrl_out_a: assert property (cw |=>
    o_tx_cycle == $past(i_wb_dat[HFC_C_CYCLE]) &&
    o_tx_crc_inhibit == $past(i_wb_dat[HFC_C_CRCINH]) &&
    o_rx_addr7 == $past(i_wb_dat[HFC_C_ADDR7]) &&
    o_rx_fifo_flush == $past(i_wb_dat[HFC_C_RXFRST]))
    else $error("control outputs wrong");
  rx_off_a: assert property (o_rx_fifo_flush && $past(o_rx_fifo_flush)
    |-> !o_rx_enable) else $error("receiver on during flush");
  tx_flush_a: assert property (cw && i_wb_dat[HFC_C_TXFRST]
    |-> ##2 !o_tx_valid) else $error("tx buffer not emptied");
  mask_zero_a: assert property (mw && i_wb_dat[7:0] == 8'h00
    |=> !o_irq) else $error("irq with all masked");
  cover property (sr ##1 o_wb_dat[1:0] == HFC_RX_ABOVE);
  cover property (cw && i_wb_dat[HFC_C_TXFRST]);
  cover property ($rose(o_irq));
endmodule // hfc_checker
bind hfc_top hfc_checker hfc_checker_inst (.i_clk, .i_nrst, .i_ce,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .i_rx_count, .i_rx_threshold, .o_rx_fifo_flush,
  .o_rx_enable, .o_rx_addr7, .o_tx_valid, .o_tx_cycle, .o_tx_crc_inhibit,
  .o_irq);
`default_nettype wire

// ==== dv/hfc_link_model.sv ====
// Transmitter side of the link: pulls head bytes and logs them.
// Assumes the bench drives the stall input right after clock edges.
`timescale 1ns/1ps
`default_nettype none
module hfc_link_model (
  input wire logic i_clk, // Clock
  input wire logic i_stall, // Hold off the transmitter
  input wire logic [7:0] i_tx_data, // Head byte
  input wire logic i_tx_valid, // Head byte valid
  output logic o_tx_ready // Wants a byte
);
  logic [7:0] q[$];
  // Pulls every cycle unless stalled, so an empty buffer means underrun
  assign o_tx_ready = !i_stall;
  always @(posedge i_clk)
    if (i_tx_valid && o_tx_ready)
      q.push_back(i_tx_data);
endmodule // hfc_link_model
`default_nettype wire

// ==== dv/hfc_top_tb_top.sv ====
// Bench for hfc_top: Wishbone tasks and a scenario sequence.
// Assumes hfc_link_model as transmitter; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module hfc_top_tb_top;
  import hfc_pkg::*;
  logic clk = 0, nrst = 0, cyc = 0, we = 0, stall = 1, fs = 0, ce = 1;
  logic ack, irq, txv, rdy, fl, en, a7, cy, ci;
  logic [7:0] adr = 0, d8 = 0, cnt = 0, thr = 4, bits = 25, ev = 0, txd;
  logic [7:0] tc[4] = '{8'h00, 8'h03, 8'h04, 8'h09};
  logic [7:0] ts[4] = '{8'h00, 8'h01, 8'h03, 8'h03};
  logic [31:0] rdat, odat;
  int bad_count = 0, checks_done = 0;
  hfc_top hfc_top_inst (.i_clk(clk), .i_nrst(nrst), .i_ce(ce),
    .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat({24'h0, d8}), .o_wb_dat(odat),
    .o_wb_ack(ack), .i_rx_count(cnt), .i_rx_threshold(thr),
    .i_rx_flag_seen(fs), .i_rx_abort(ev[2]), .i_rx_bit_count(bits),
    .i_go_ahead_seen(ev[7]), .i_rx_packet_end(ev[6]),
    .i_last_byte_read(ev[4]), .i_rx_fifo_full(ev[1]),
    .i_rx_overflow(ev[0]), .o_rx_fifo_flush(fl), .o_rx_enable(en),
    .o_rx_addr7(a7), .i_tx_ready(rdy), .i_tx_packet_done(ev[5]),
    .i_tx_fifo_low(ev[3]), .o_tx_data(txd), .o_tx_valid(txv),
    .o_tx_cycle(cy), .o_tx_crc_inhibit(ci), .o_irq(irq));
  hfc_link_model hfc_link_model_inst (.i_clk(clk), .i_stall(stall),
    .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(rdy));
  initial forever #2 clk = ~clk;
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    d8 <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = odat;
    if (ack !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: no bus acknowledge", $time);
      results();
    end
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  task automatic pulse(input logic [7:0] e);
    ev <= e;
    @(posedge clk);
    ev <= 8'h00;
    @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(HFC_IDX_MASK, 8'h00);
    rd(8'h30, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cnt <= tc[i];
      rd(HFC_IDX_STATUS, ts[i]);
    end
    acc(1'b1, HFC_IDX_CTRL2, 8'hf3);
    rd(HFC_IDX_CTRL2, 8'hf3);
    chk({cy, ci, a7, fl, en}, 5'h1e);
    rd(HFC_IDX_STATUS, 8'h00);
    acc(1'b1, HFC_IDX_CTRL2, 8'h00);
    chk(en, 1'b0);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    @(posedge clk);
    chk(en, 1'b1);
    acc(1'b1, HFC_IDX_TXDATA, 8'ha1);
    acc(1'b1, HFC_IDX_TXDATA, 8'ha2);
    fork
      acc(1'b1, HFC_IDX_TXDATA, 8'ha3);
      begin
        repeat (8) @(posedge clk);
        stall <= 1'b0;
      end
    join
    repeat (4) @(posedge clk);
    stall <= 1'b1;
    chk(hfc_link_model_inst.q.size(), 3);
    acc(1'b1, HFC_IDX_TXDATA, 8'hb1);
    acc(1'b1, HFC_IDX_CTRL2, 8'h01);
    chk(txv, 1'b0);
    acc(1'b1, HFC_IDX_TXDATA, 8'hb2);
    rd(HFC_IDX_CTRL2, 8'h00);
    chk({txv, txd}, 9'h1b2);
    acc(1'b1, HFC_IDX_MASK, 8'h04);
    stall <= 1'b0;
    acc(1'b1, HFC_IDX_CTRL2, 8'h80);
    chk(irq, 1'b1);
    stall <= 1'b1;
    acc(1'b1, HFC_IDX_CTRL2, 8'h00);
    chk(hfc_link_model_inst.q[3], 8'hb2);
    rd(HFC_IDX_INTR, 8'h04);
    rd(HFC_IDX_INTR, 8'h00);
    chk(irq, 1'b0);
    pulse(8'h04);
    rd(HFC_IDX_INTR, 8'h00);
    bits <= 8'h1a;
    acc(1'b1, HFC_IDX_MASK, 8'h00);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      chk(irq, 1'b0);
      rd(HFC_IDX_INTR, 8'h01 << i);
    end
    acc(1'b1, HFC_IDX_MASK, 8'hff);
    pulse(8'h80);
    chk(irq, 1'b1);
    // Clock enable low: the event pulse must be lost, flags kept
    ce <= 1'b0;
    pulse(8'h01);
    ce <= 1'b1;
    rd(HFC_IDX_INTR, 8'h80);
    chk(irq, 1'b0);
    results();
  end
endmodule // hfc_top_tb_top
`default_nettype wire

// ==== verilog/hfc_pkg.sv ====
// Constants for the HDLC FIFO control, status and interrupt mask block.
// Assumes a Wishbone slave with byte address = 4 * register index.
package hfc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] HFC_IDX_STATUS = 8'h14;
  localparam logic [7:0] HFC_IDX_CTRL2 = 8'h15;
  localparam logic [7:0] HFC_IDX_MASK = 8'h16;
  localparam logic [7:0] HFC_IDX_INTR = 8'h17;
  localparam logic [7:0] HFC_IDX_TXDATA = 8'h20;
  // Control two fields
  localparam int HFC_C_INTSEL = 7;
  localparam int HFC_C_CYCLE = 6;
  localparam int HFC_C_CRCINH = 5;
  localparam int HFC_C_ADDR7 = 4;
  localparam int HFC_C_RXFRST = 1;
  localparam int HFC_C_TXFRST = 0;
  // Interrupt register fields
  localparam int HFC_I_GA = 7;
  localparam int HFC_I_RXEOP = 6;
  localparam int HFC_I_TXEOP = 5;
  localparam int HFC_I_EOPRD = 4;
  localparam int HFC_I_TXLOW = 3;
  localparam int HFC_I_ABUND = 2;
  localparam int HFC_I_RXFULL = 1;
  localparam int HFC_I_RXOVF = 0;
  // Reset values
  localparam logic [7:0] HFC_CTRL2_RST = 8'h00;
  localparam logic [7:0] HFC_MASK_RST = 8'h00;
  localparam logic [7:0] HFC_INTR_RST = 8'h00;
  // Control bits that software may set; reserved bits 3 and 2 excluded
  localparam logic [7:0] HFC_CTRL2_WMASK = 8'hf3;
  // Least packet length before an abort counts
  localparam logic [7:0] HFC_ABORT_MIN_BITS = 8'h1a;
  // Receive FIFO status codes
  localparam logic [1:0] HFC_RX_EMPTY = 2'h0;
  localparam logic [1:0] HFC_RX_BELOW = 2'h1;
  localparam logic [1:0] HFC_RX_ABOVE = 2'h3;
endpackage

// ==== verilog/hfc_top.sv ====
// HDLC FIFO control, receive status and interrupt masking, Wishbone slave.
// Assumes the HDLC transmitter, receiver and RX FIFO run on i_clk and
// drive the event and level inputs directly; no synchronisers needed.
// Notes on behaviour
// RL1: Status bits 1:0 give RX FIFO state; 00 when it is empty.
// RL2: Code 01 when RX FIFO holds bytes but fewer than threshold.
// RL3: Code 11 when stored RX bytes reach or exceed threshold.
// RL4: Control bit 7 picks TX underrun or frame abort for interrupt bit 2.
// RL5: Control bit 6 makes the transmit byte count cycle repeatedly.
// RL6: Control bit 5 stops the transmitter appending its CRC.
// RL7: Control bit 4 enables seven-bit address match, address bit 0 set.
// RL8: Software writes zero to reserved control bits 3 and 2.
// RL9: Control bit 1 empties RX FIFO, receiver off until next flag.
// RL10: RX FIFO reset clears pointers and status, never stored data.
// RL11: Control bit 0 empties TX FIFO without clearing stored data.
// RL12: TX FIFO reset bit clears on the next write into the TX FIFO.
// RL13: Mask bits gate interrupt sources; masked sources still set flags.
// RL14: Mask bit 0 disables its source, 1 enables it.
// RL15: Mask register resets to all zeros.
// RL16: Interrupt flags clear when software reads the interrupt register.
// RL17: Underrun flags a transmitter read from an empty TX FIFO.
// RL18: Frame abort counts only after at least 26 packet bits.
// RL19: Interrupt request high while any flag and its mask bit are set.
`timescale 1ns/1ps
`default_nettype none
module hfc_top (
  input wire logic i_clk, // 250 MHz clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_ce, // Clock enable, freezes state when low
  // Wishbone classic slave
  input wire logic i_wb_cyc, // Bus cycle
  input wire logic i_wb_stb, // Strobe
  input wire logic i_wb_we, // Write enable
  input wire logic [9:2] i_wb_adr, // Word address (register index)
  input wire logic [3:0] i_wb_sel, // Byte lanes
  input wire logic [31:0] i_wb_dat, // Write data
  output logic [31:0] o_wb_dat, // Read data
  output logic o_wb_ack, // Acknowledge
  // Receive side
  input wire logic [7:0] i_rx_count, // Bytes held in RX FIFO
  input wire logic [7:0] i_rx_threshold, // RX FIFO status threshold
  input wire logic i_rx_flag_seen, // Receiver saw a flag sequence
  input wire logic i_rx_abort, // Receiver saw an abort, pulse
  input wire logic [7:0] i_rx_bit_count, // Bits of packet so far
  input wire logic i_go_ahead_seen, // Go-ahead detected, pulse
  input wire logic i_rx_packet_end, // EOP byte stored, pulse
  input wire logic i_last_byte_read, // Last byte about to be read, pulse
  input wire logic i_rx_fifo_full, // RX FIFO above full level, pulse
  input wire logic i_rx_overflow, // RX FIFO overflow, pulse
  output logic o_rx_fifo_flush, // Reset RX FIFO pointers
  output logic o_rx_enable, // Receiver enabled
  output logic o_rx_addr7, // Seven-bit address recognition
  // Transmit side
  input wire logic i_tx_ready, // Transmitter takes a byte
  input wire logic i_tx_packet_done, // Closing flag sent, pulse
  input wire logic i_tx_fifo_low, // TX FIFO below low level, pulse
  output logic [7:0] o_tx_data, // Head byte for transmitter
  output logic o_tx_valid, // Head byte valid
  output logic o_tx_cycle, // Cycle transmit byte count
  output logic o_tx_crc_inhibit, // Do not append CRC
  output logic o_irq // Interrupt request, active high
);
  import hfc_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0] intr;
    logic rx_en;
    logic [7:0] e0;
    logic [7:0] e1;
    logic [1:0] cnt;
    logic tx_valid;
    logic irq;
  } hfc_state_t;

  hfc_state_t st;
  hfc_state_t next_st;

  // Receive FIFO status code from fill level and threshold
  function automatic logic [1:0] hfc_rx_code(input logic [7:0] cnt,
                                             input logic [7:0] thr,
                                             input logic flush);
    if (flush || cnt == 8'h00) begin
      hfc_rx_code = HFC_RX_EMPTY; // RL1 RL9
    end else if (cnt < thr) begin
      hfc_rx_code = HFC_RX_BELOW; // RL2
    end else begin
      hfc_rx_code = HFC_RX_ABOVE; // RL3
    end
  endfunction

  logic req;
  logic wr;
  logic rd;
  logic lane0;
  logic txd_hit;
  logic tx_room;
  logic tx_pop;
  logic tx_push;
  logic [7:0] ev;
  logic abort_ok;
  logic underrun;
  logic [1:0] cnt_after_pop;

  always_comb begin
    next_st = st;
    req = i_wb_cyc && i_wb_stb && !st.ack;
    wr = req && i_wb_we;
    rd = req && !i_wb_we;
    lane0 = i_wb_sel[0];
    txd_hit = (i_wb_adr == HFC_IDX_TXDATA);
    // Full buffer holds the bus write until the transmitter drains
    tx_room = (st.cnt != 2'h2) || i_tx_ready;
    tx_pop = st.tx_valid && i_tx_ready;
    tx_push = wr && txd_hit && lane0 && tx_room;
    underrun = i_tx_ready && !st.tx_valid; // RL17
    abort_ok = i_rx_abort && (i_rx_bit_count >= HFC_ABORT_MIN_BITS); // RL18

    // Event sources in interrupt register order
    ev = 8'h00;
    ev[HFC_I_GA] = i_go_ahead_seen;
    ev[HFC_I_RXEOP] = i_rx_packet_end;
    ev[HFC_I_TXEOP] = i_tx_packet_done;
    ev[HFC_I_EOPRD] = i_last_byte_read;
    ev[HFC_I_TXLOW] = i_tx_fifo_low;
    ev[HFC_I_ABUND] = st.ctrl[HFC_C_INTSEL] ? underrun : abort_ok; // RL4
    ev[HFC_I_RXFULL] = i_rx_fifo_full;
    ev[HFC_I_RXOVF] = i_rx_overflow;

    // Bus answer: one cycle after the request, or later for a full buffer
    next_st.ack = 1'b0;
    next_st.rdat = 32'h0000_0000;
    if (req && !(i_wb_we && txd_hit && lane0 && !tx_room)) begin
      next_st.ack = 1'b1;
    end

    if (rd) begin
      case (i_wb_adr)
        HFC_IDX_STATUS: begin
          next_st.rdat[1:0] = hfc_rx_code(i_rx_count, i_rx_threshold,
                                          st.ctrl[HFC_C_RXFRST]);
        end
        HFC_IDX_CTRL2: begin
          next_st.rdat[7:0] = st.ctrl;
        end
        HFC_IDX_MASK: begin
          next_st.rdat[7:0] = st.mask;
        end
        HFC_IDX_INTR: begin
          next_st.rdat[7:0] = st.intr;
        end
        default: begin
          next_st.rdat = 32'h0000_0000;
        end
      endcase
    end

    // Sticky flags; a read clears, a same-cycle event wins
    if (rd && i_wb_adr == HFC_IDX_INTR) begin
      next_st.intr = 8'h00; // RL16
    end
    next_st.intr = next_st.intr | ev; // RL13

    if (wr && lane0) begin
      if (i_wb_adr == HFC_IDX_CTRL2) begin
        // Reserved bits kept at zero regardless of the write
        next_st.ctrl = i_wb_dat[7:0] & HFC_CTRL2_WMASK; // RL8
      end
      if (i_wb_adr == HFC_IDX_MASK) begin
        next_st.mask = i_wb_dat[7:0]; // RL14
      end
    end

    // Receiver stays off after an RX FIFO reset until a flag arrives
    if (next_st.ctrl[HFC_C_RXFRST]) begin
      next_st.rx_en = 1'b0; // RL9
    end else if (i_rx_flag_seen) begin
      next_st.rx_en = 1'b1; // RL9
    end

    // Two-entry TX buffer; head entry drives the transmitter directly
    cnt_after_pop = st.cnt;
    if (tx_pop) begin
      next_st.e0 = st.e1;
      cnt_after_pop = st.cnt - 2'h1;
    end
    if (st.ctrl[HFC_C_TXFRST]) begin
      // Only the occupancy is dropped; stored bytes stay as they were
      cnt_after_pop = 2'h0; // RL11
    end
    next_st.cnt = cnt_after_pop;
    if (tx_push) begin
      if (cnt_after_pop == 2'h0) begin
        next_st.e0 = i_wb_dat[7:0];
      end else begin
        next_st.e1 = i_wb_dat[7:0];
      end
      next_st.cnt = cnt_after_pop + 2'h1;
      next_st.ctrl[HFC_C_TXFRST] = 1'b0; // RL12
    end
    next_st.tx_valid = (next_st.cnt != 2'h0);

    next_st.irq = |(next_st.intr & next_st.mask); // RL13 RL19
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st.ack <= 1'b0;
      st.rdat <= 32'h0000_0000;
      st.ctrl <= HFC_CTRL2_RST;
      st.mask <= HFC_MASK_RST; // RL15
      st.intr <= HFC_INTR_RST;
      st.rx_en <= 1'b1;
      st.e0 <= 8'h00;
      st.e1 <= 8'h00;
      st.cnt <= 2'h0;
      st.tx_valid <= 1'b0;
      st.irq <= 1'b0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_wb_ack = st.ack;
  assign o_wb_dat = st.rdat;
  assign o_rx_fifo_flush = st.ctrl[HFC_C_RXFRST]; // RL9 RL10
  // Held as an enable so the pin needs no inverter after the flop
  assign o_rx_enable = st.rx_en; // RL9
  assign o_rx_addr7 = st.ctrl[HFC_C_ADDR7]; // RL7
  assign o_tx_data = st.e0;
  assign o_tx_valid = st.tx_valid;
  assign o_tx_cycle = st.ctrl[HFC_C_CYCLE]; // RL5
  assign o_tx_crc_inhibit = st.ctrl[HFC_C_CRCINH]; // RL6
  assign o_irq = st.irq;
endmodule // hfc_top
`default_nettype wire
